// [logic/lfb_frame_buffer.v]
// LIN frame buffer registers behind an AXI4-Lite slave.
// Assumes a framing engine that reads and fills response bytes.
//
// Function
// [RL1] LIN mode: transmit length from upper nibble, values above eight act as eight.
// [RL2] LIN mode: receive length from lower nibble, saturating at eight.
// [RL3] UART mode ignores length, identifier and buffer select fields.
// [RL4] Parity bit zero at bit 6 is xor of identifier bits 4,2,1,0.
// [RL5] Parity bit one at bit 7 is inverted xor of bits 1,3,4,5.
// [RL6] Revision 1.3: bits 5:4 give length 2,2,4 or 8 bytes.
// [RL7] Revision 1.3: frame identifier is bits 3:0.
// [RL8] Revision 2.1: frame identifier is bits 5:0, no length carried.
// [RL9] Buffer select bit 3 zero steps the index, one holds it.
// [RL10] LIN mode: buffer select bits 2:0 pick the buffer slot reached.
// [RL11] LIN mode data port reaches buffer; UART mode plain data register.
// [RL12] Data port write gives outgoing data, read returns incoming data.
// [RL13] Software writes zeros to buffer select bits 7:4.
// [RL14] UART mode: data port write clears the transmit complete flag.
// [RL15] Stepping index advances after each LIN mode data port read or lane 0 write, wrapping seven to zero.
`timescale 1ns/100ps
`include "lfb_consts.vh"
module lfb_frame_buffer #(
  parameter ADDR_W = 8,
  parameter BUF_DEPTH = 8,
  parameter FIFO_DEPTH = 8
) (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Framing engine side
  output reg lin_mode,
  output reg [3:0] tx_length,
  output reg [3:0] rx_length,
  output reg [5:0] frame_ident,
  output reg [3:0] legacy_length_code,
  output reg [1:0] parity_bits,
  input wire [2:0] tx_rd_index,
  output reg [7:0] tx_rd_data,
  input wire rx_start,
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  output wire rx_byte_ready,
  output reg [7:0] uart_tx_data,
  output reg uart_tx_load,
  input wire tx_done,
  output reg tx_complete_flag
);
  // Saturate a four-bit length at eight
  function [3:0] sat8;
    input [3:0] len;
    begin
      sat8 = (len > `LFB_MAX_LEN) ? `LFB_MAX_LEN : len;
    end
  endfunction

  // Address decode for the buffer port, shared by both channels
  function hits_data_port;
    input [ADDR_W-1:0] addr;
    begin
      hits_data_port = (addr == `LFB_OFS_DATA_PORT);
    end
  endfunction

  // Software-visible state
  reg [7:0] response_length;
  reg [5:0] ident_bits;
  reg index_autostep_off;
  reg [2:0] buffer_index;
  reg [1:0] mode_bits;
  reg [7:0] uart_rx_data;
  reg [7:0] resp_buf [0:BUF_DEPTH-1];
  // Counts up to eight so a full response stops further stores
  reg [3:0] rx_wr_idx;
  integer j;

  // Write channel capture
  reg aw_held;
  reg w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write;
  wire do_read;
  wire wr_lane0;
  wire [ADDR_W-1:0] rd_addr;

  // Identifier decode results
  wire par0;
  wire par1;
  wire [5:0] id_eff;
  wire [3:0] id_len;

  // Receive FIFO drain
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire fifo_ready;
  wire sw_buf_access;
  wire sw_buf_write;
  wire step_index;
  wire rx_take;
  wire uart_take;

  lfb_id_calc i_lfb_id_calc (
    .ident(ident_bits),
    .rev21(mode_bits[`LFB_MODE_REV21_BIT]),
    .parity_bit_zero(par0),
    .parity_bit_one(par1),
    .frame_ident(id_eff),
    .legacy_length(id_len)
  );

  lfb_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) i_lfb_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(rx_byte_valid),
    .in_data(rx_byte),
    .in_ready(rx_byte_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_ready)
  );

  // Bus decode
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign wr_lane0 = w_strb[0];
  assign rd_addr = s_axi_araddr;

  // Software writes the buffer through the data port in LIN mode
  assign sw_buf_write = lin_mode && do_write && wr_lane0 && hits_data_port(aw_addr); // RL11
  // LIN mode read or lane 0 write of the buffer port; one access steps once
  assign sw_buf_access = sw_buf_write || (lin_mode && do_read && hits_data_port(rd_addr)); // RL11
  assign step_index = sw_buf_access && !index_autostep_off; // RL9 RL15
  // The drain waits while software holds the buffer port
  assign fifo_ready = !sw_buf_access;
  // Drained bytes fill slots only up to the expected count
  assign rx_take = fifo_valid && fifo_ready && lin_mode && (rx_wr_idx < rx_length); // RL2
  // UART mode keeps just the latest byte
  assign uart_take = fifo_valid && fifo_ready && !lin_mode; // RL11

  // Write address and data capture, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LFB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `LFB_OFS_RESP_LEN, `LFB_OFS_FRAME_ID, `LFB_OFS_BUF_SEL,
          `LFB_OFS_DATA_PORT, `LFB_OFS_MODE, `LFB_OFS_STATUS: s_axi_bresp <= `LFB_RESP_OKAY;
          default: s_axi_bresp <= `LFB_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register writes and index stepping
  always @(posedge aclk) begin
    if (!aresetn) begin
      response_length <= `LFB_RST_RESP_LEN;
      ident_bits <= `LFB_RST_FRAME_ID;
      index_autostep_off <= 1'b0;
      buffer_index <= 3'h0;
      mode_bits <= `LFB_RST_MODE;
      uart_tx_data <= `LFB_RST_DATA;
      uart_tx_load <= 1'b0;
    end else begin
      uart_tx_load <= 1'b0;
      if (step_index) begin
        buffer_index <= buffer_index + 3'h1; // RL15
      end
      if (do_write && wr_lane0) begin
        case (aw_addr)
          `LFB_OFS_RESP_LEN: response_length <= w_data[7:0];
          `LFB_OFS_FRAME_ID: ident_bits <= w_data[5:0];
          // Upper bits are not stored and read back as zero
          `LFB_OFS_BUF_SEL: begin
            index_autostep_off <= w_data[`LFB_AUTOSTEP_OFF_BIT]; // RL9 RL13
            buffer_index <= w_data[2:0]; // RL10
          end
          // UART mode: plain transmit register, no buffering
          `LFB_OFS_DATA_PORT: begin
            if (!lin_mode) begin
              uart_tx_data <= w_data[7:0]; // RL11 RL12
              uart_tx_load <= 1'b1;
            end
          end
          `LFB_OFS_MODE: mode_bits <= w_data[1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Response buffer: cleared at reset, then software writes and drained receive bytes
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (j = 0; j < BUF_DEPTH; j = j + 1) begin
        resp_buf[j] <= 8'h00;
      end
    end else if (sw_buf_write) begin
      resp_buf[buffer_index] <= w_data[7:0]; // RL10 RL12
    end else if (rx_take) begin
      resp_buf[rx_wr_idx[2:0]] <= fifo_data; // RL2
    end
  end

  // Receive slot counter and plain UART receive register
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_wr_idx <= 4'h0;
      uart_rx_data <= `LFB_RST_DATA;
    end else begin
      // A frame start rewinds to slot zero
      if (rx_start) begin
        rx_wr_idx <= 4'h0;
      end else if (rx_take) begin
        rx_wr_idx <= rx_wr_idx + 4'h1; // RL2
      end
      if (uart_take) begin
        uart_rx_data <= fifo_data; // RL11
      end
    end
  end

  // Transmit complete flag; a new event beats the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_complete_flag <= 1'b0;
    end else if (tx_done) begin
      tx_complete_flag <= 1'b1;
    end else if (do_write && wr_lane0 && aw_addr == `LFB_OFS_DATA_PORT && !lin_mode) begin
      tx_complete_flag <= 1'b0; // RL14
    end else if (do_write && wr_lane0 && aw_addr == `LFB_OFS_STATUS && w_data[`LFB_STAT_TXOK_BIT]) begin
      tx_complete_flag <= 1'b0;
    end
  end

  // Values presented to the framing engine; all but lin_mode and tx_rd_data blanked in UART mode
  always @(posedge aclk) begin
    if (!aresetn) begin
      lin_mode <= 1'b0;
      tx_length <= 4'h0;
      rx_length <= 4'h0;
      frame_ident <= 6'h00;
      legacy_length_code <= 4'h0;
      parity_bits <= 2'h0;
      tx_rd_data <= 8'h00;
    end else begin
      lin_mode <= mode_bits[`LFB_MODE_LIN_BIT];
      if (mode_bits[`LFB_MODE_LIN_BIT]) begin
        tx_length <= sat8(response_length[`LFB_TXLEN_HI:`LFB_TXLEN_LO]); // RL1
        rx_length <= sat8(response_length[`LFB_RXLEN_HI:`LFB_RXLEN_LO]); // RL2
        frame_ident <= id_eff; // RL7 RL8
        legacy_length_code <= id_len; // RL6
        parity_bits <= {par1, par0}; // RL4 RL5
      end else begin
        tx_length <= 4'h0; // RL3
        rx_length <= 4'h0;
        frame_ident <= 6'h00;
        legacy_length_code <= 4'h0;
        parity_bits <= 2'h0;
      end
      tx_rd_data <= resp_buf[tx_rd_index];
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LFB_RESP_OKAY;
    end else if (do_read) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `LFB_RESP_OKAY;
      case (rd_addr)
        `LFB_OFS_RESP_LEN: s_axi_rdata <= {24'h000000, response_length};
        // Parity reads as zero outside LIN mode, matching the reset value
        `LFB_OFS_FRAME_ID: s_axi_rdata <= {24'h000000, lin_mode ? {par1, par0} : 2'b00, ident_bits}; // RL4 RL5
        `LFB_OFS_BUF_SEL: s_axi_rdata <= {28'h0000000, index_autostep_off, buffer_index};
        `LFB_OFS_DATA_PORT: s_axi_rdata <= {24'h000000, lin_mode ? resp_buf[buffer_index] : uart_rx_data}; // RL12
        `LFB_OFS_MODE: s_axi_rdata <= {30'h00000000, mode_bits};
        // Status: transmit complete in bit 0, slot count above it
        `LFB_OFS_STATUS: s_axi_rdata <= {27'h0, rx_wr_idx, tx_complete_flag};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `LFB_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// [logic/lfb_consts.vh]
// Constants for the LIN frame buffer register block.
// Included by the buffer and identifier design files; definitions only.
`ifndef LFB_CONSTS_VH
`define LFB_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus
`define LFB_OFS_RESP_LEN 8'h00
`define LFB_OFS_FRAME_ID 8'h04
`define LFB_OFS_BUF_SEL 8'h08
`define LFB_OFS_DATA_PORT 8'h0C
`define LFB_OFS_MODE 8'h10
`define LFB_OFS_STATUS 8'h14

// Field positions
`define LFB_TXLEN_HI 7
`define LFB_TXLEN_LO 4
`define LFB_RXLEN_HI 3
`define LFB_RXLEN_LO 0
`define LFB_PAR1_BIT 7
`define LFB_PAR0_BIT 6
`define LFB_AUTOSTEP_OFF_BIT 3
`define LFB_MODE_LIN_BIT 0
`define LFB_MODE_REV21_BIT 1
`define LFB_STAT_TXOK_BIT 0

// Reset values
`define LFB_RST_RESP_LEN 8'h00
`define LFB_RST_FRAME_ID 6'h00
`define LFB_RST_BUF_SEL 4'h0
`define LFB_RST_DATA 8'h00
`define LFB_RST_MODE 2'h0

// Length limit and bus answers
`define LFB_MAX_LEN 4'h8
`define LFB_RESP_OKAY 2'h0
`define LFB_RESP_SLVERR 2'h2

`endif

// [logic/lfb_fifo.v]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; in_ready and count are registered.
`timescale 1ns/100ps
module lfb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire aclk,
  input wire aresetn,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output reg in_ready,
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  reg [AW:0] next_count;

  // Handshakes
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];

  // Occupancy after this edge
  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Storage
  always @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and registered full indication
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != DEPTH);
    end
  end
endmodule

// [logic/lfb_id_calc.v]
// Identifier decode: parity bits, frame identifier and legacy length.
// Purely combinational; the caller registers the results.
`timescale 1ns/100ps
`include "lfb_consts.vh"
module lfb_id_calc (
  input wire [5:0] ident,
  input wire rev21,
  output wire parity_bit_zero,
  output wire parity_bit_one,
  output wire [5:0] frame_ident,
  output reg [3:0] legacy_length
);
  // Protected identifier parity
  assign parity_bit_zero = ident[4] ^ ident[2] ^ ident[1] ^ ident[0]; // RL4
  assign parity_bit_one = ~(ident[1] ^ ident[3] ^ ident[4] ^ ident[5]); // RL5

  // Older revision keeps only four identifier bits
  assign frame_ident = rev21 ? ident : {2'b00, ident[3:0]}; // RL7 RL8

  // Length carried in the top two identifier bits
  always @* begin
    legacy_length = 4'h0;
    if (!rev21) begin
      case (ident[5:4]) // RL6
        2'b00: legacy_length = 4'h2;
        2'b01: legacy_length = 4'h2;
        2'b10: legacy_length = 4'h4;
        2'b11: legacy_length = 4'h8;
        default: legacy_length = 4'h2;
      endcase
    end
  end
endmodule

// [bench/lfb_frame_buffer_props.sv]
// Checker for the frame buffer register block.
// Bound to the top module; sees its ports only.
`timescale 1ns/100ps
module lfb_frame_buffer_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire lin_mode,
  input wire [3:0] tx_length,
  input wire [3:0] rx_length,
  input wire [5:0] frame_ident,
  input wire [3:0] legacy_length_code,
  input wire [1:0] parity_bits,
  input wire uart_tx_load,
  input wire tx_done,
  input wire tx_complete_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Lengths saturate, UART hides fields
  property p_tx_sat; tx_length <= 4'h8; endproperty
  a_tx_sat: assert property (p_tx_sat) else $error("tx length over 8");
  property p_rx_sat; rx_length <= 4'h8; endproperty
  a_rx_sat: assert property (p_rx_sat) else $error("rx length over 8");
  property p_uart_quiet; !lin_mode && !$past(lin_mode) |-> {tx_length, rx_length, frame_ident,
    parity_bits, legacy_length_code} == 20'h0; endproperty
  a_uart_quiet: assert property (p_uart_quiet) else $error("fields live in uart");
  // Parity in full identifier mode
  property p_par0; lin_mode && $past(lin_mode) && legacy_length_code == 4'h0 |->
    parity_bits[0] == (frame_ident[4] ^ frame_ident[2] ^ frame_ident[1] ^ frame_ident[0]); endproperty
  a_par0: assert property (p_par0) else $error("parity zero wrong");
  property p_par1; lin_mode && $past(lin_mode) && legacy_length_code == 4'h0 |->
    parity_bits[1] == !(frame_ident[1] ^ frame_ident[3] ^ frame_ident[4] ^ frame_ident[5]); endproperty
  a_par1: assert property (p_par1) else $error("parity one wrong");
  property p_legacy; lin_mode && legacy_length_code != 4'h0 |->
    legacy_length_code inside {4'h2, 4'h4, 4'h8} && frame_ident[5:4] == 2'h0; endproperty
  a_legacy: assert property (p_legacy) else $error("legacy length odd");
  // Data port side effects and read answer
  property p_flag_clear; uart_tx_load && !$past(tx_done) |-> !tx_complete_flag; endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  c_legacy8: cover property (lin_mode && legacy_length_code == 4'h8);
  c_load: cover property (uart_tx_load);
  c_sat: cover property (lin_mode && tx_length == 4'h8 && rx_length == 4'h8);
endmodule
bind lfb_frame_buffer lfb_frame_buffer_props i_lfb_frame_buffer_props (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .lin_mode, .tx_length, .rx_length, .frame_ident,
  .legacy_length_code, .parity_bits, .uart_tx_load, .tx_done, .tx_complete_flag);

// [bench/lfb_engine_model.sv]
// Framing engine stand-in: feeds bytes, pulses done, scans slots.
// Assumes the bench fills q and sets slow.
`timescale 1ns/100ps
module lfb_engine_model (
  input wire aclk,
  input wire slow,
  output reg [2:0] tx_rd_index = 3'h0,
  input wire [7:0] tx_rd_data,
  output reg rx_start = 1'b0,
  output reg rx_byte_valid = 1'b0,
  output reg [7:0] rx_byte = 8'h00,
  input wire rx_byte_ready,
  output reg tx_done = 1'b0
);
  reg [7:0] q [$];
  reg [7:0] seen [0:7];
  reg [2:0] last = 3'h0;
  integer gap = 0;
  // Scan slots; hold a byte until taken, garble the idle line
  always @(posedge aclk) begin
    tx_rd_index <= tx_rd_index + 3'h1;
    last <= tx_rd_index;
    seen[last] <= tx_rd_data;
    if (rx_byte_valid && rx_byte_ready && !slow && q.size() > 0)
      rx_byte <= q.pop_front();
    else if (rx_byte_valid && rx_byte_ready) begin
      rx_byte_valid <= 1'b0;
      rx_byte <= ~rx_byte;
      gap <= 3;
    end else if (!rx_byte_valid && gap > 0) begin
      gap <= gap - 1;
      rx_byte <= ~rx_byte;
    end else if (!rx_byte_valid && q.size() > 0) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= q.pop_front();
    end
  end
  // One-cycle pulse of done or start
  task kick(input reg done);
    begin
      @(posedge aclk);
      if (done) tx_done <= 1'b1;
      else rx_start <= 1'b1;
      @(posedge aclk);
      tx_done <= 1'b0;
      rx_start <= 1'b0;
    end
  endtask
endmodule

// [bench/lfb_frame_buffer_bench.sv]
// Self-checking bench for the frame buffer register block.
// Drives AXI4-Lite as master; engine model on the far side.
`timescale 1ns/100ps
module lfb_frame_buffer_bench;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [7:0] s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 1'b0;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  reg slow = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lin_mode, rx_start;
  wire rx_byte_valid, rx_byte_ready, uart_tx_load, tx_done, tx_complete_flag;
  wire [1:0] s_axi_bresp, s_axi_rresp, parity_bits;
  wire [31:0] s_axi_rdata;
  wire [3:0] tx_length, rx_length, legacy_length_code;
  wire [5:0] frame_ident;
  wire [2:0] tx_rd_index;
  wire [7:0] tx_rd_data, rx_byte, uart_tx_data;
  integer fails = 0;
  integer compares = 0;
  integer seed = 27378;
  integer i, k;
  reg [31:0] v, got;
  reg [1:0] r;
  lfb_frame_buffer i_lfb_frame_buffer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lin_mode(lin_mode),
    .tx_length(tx_length), .rx_length(rx_length), .frame_ident(frame_ident),
    .legacy_length_code(legacy_length_code), .parity_bits(parity_bits), .tx_rd_index(tx_rd_index),
    .tx_rd_data(tx_rd_data), .rx_start(rx_start), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_byte_ready(rx_byte_ready), .uart_tx_data(uart_tx_data), .uart_tx_load(uart_tx_load),
    .tx_done(tx_done), .tx_complete_flag(tx_complete_flag));
  lfb_engine_model i_lfb_engine_model (.aclk(aclk), .slow(slow), .tx_rd_index(tx_rd_index),
    .tx_rd_data(tx_rd_data), .rx_start(rx_start), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_byte_ready(rx_byte_ready), .tx_done(tx_done));
  // Clock
  initial forever #20 aclk = ~aclk;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Bus write, response code in r
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 40; k = k + 1) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          r = s_axi_bresp;
          s_axi_bready <= 1'b0;
          k = 99;
        end
      end
      if (k == 40) begin
        fails = fails + 1;
        close_out;
      end
    end
  endtask
  // Bus read, response code in r
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 40; k = k + 1) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          d = s_axi_rdata;
          r = s_axi_rresp;
          s_axi_rready <= 1'b0;
          k = 99;
        end
      end
      if (k == 40) begin
        fails = fails + 1;
        close_out;
      end
    end
  endtask
  function [3:0] sat(input [3:0] n);
    sat = n > 4'h8 ? 4'h8 : n;
  endfunction
  function [7:0] idreg(input [5:0] d);
    idreg = {~(d[1] ^ d[3] ^ d[4] ^ d[5]), d[4] ^ d[2] ^ d[1] ^ d[0], d};
  endfunction
  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      rd({i[5:0], 2'h0}, got);
      chk(got, 0);
    end
    chk(rx_byte_ready, 1'b1);
    wr(8'h1C, 32'h1);
    chk(r, 2'h2);
    rd(8'h1C, got);
    chk(got, 0);
    chk(r, 2'h2);
    wr(8'h10, 32'h1);
    // Length corners then random
    for (i = 0; i < 12; i = i + 1) begin
      v = i < 4 ? 32'h88 + 32'h11 * i : $random(seed);
      wr(8'h00, v);
      rd(8'h00, got);
      chk(got, v[7:0]);
      chk(tx_length, sat(v[7:4]));
      chk(rx_length, sat(v[3:0]));
    end
    // Identifier in both revisions, every length code
    for (i = 0; i < 16; i = i + 1) begin
      if (i == 8) wr(8'h10, 32'h3);
      v = $random(seed);
      v[5:4] = i[1:0];
      wr(8'h04, v);
      rd(8'h04, got);
      chk(got, idreg(v[5:0]));
      chk(parity_bits, idreg(v[5:0]) >> 6);
      chk(frame_ident, i < 8 ? v[3:0] : v[5:0]);
      chk(legacy_length_code, i > 7 ? 0 : v[5] ? (v[4] ? 8 : 4) : 2);
    end
    // Fill all slots plus one to wrap
    wr(8'h08, 32'h0);
    for (i = 0; i < 9; i = i + 1)
      wr(8'h0C, 32'h30 + i);
    rd(8'h08, got);
    chk(got, 32'h1);
    wr(8'h08, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      rd(8'h0C, got);
      chk(got, i ? 32'h30 + i : 32'h38);
      chk(i_lfb_engine_model.seen[i], i ? 32'h30 + i : 32'h38);
    end
    // Fixed index, then a write with lane 0 off
    wr(8'h08, 32'h0B);
    wr(8'h0C, 32'h5A);
    wr(8'h0C, 32'hA5);
    s_axi_wstrb <= 4'hE;
    wr(8'h0C, 32'h11);
    s_axi_wstrb <= 4'hF;
    rd(8'h0C, got);
    chk(got, 32'hA5);
    rd(8'h08, got);
    chk(got, 32'h0B);
    // Receive five bytes into a three byte response
    wr(8'h00, 32'h03);
    wr(8'h08, 32'h0);
    slow <= 1'b1;
    i_lfb_engine_model.kick(1'b0);
    for (i = 0; i < 5; i = i + 1)
      i_lfb_engine_model.q.push_back(8'hC0 + i[7:0]);
    got = 0;
    for (i = 0; i < 30 && got[3:1] !== 3'h3; i = i + 1)
      rd(8'h14, got);
    chk(got[3:1], 3);
    for (i = 0; i < 4; i = i + 1) begin
      rd(8'h0C, got);
      chk(got, i < 3 ? 32'hC0 + i : 32'hA5);
    end
    // UART mode: plain data register
    wr(8'h10, 32'h0);
    slow <= 1'b0;
    i_lfb_engine_model.kick(1'b1);
    rd(8'h14, got);
    chk(got[0], 1'b1);
    chk({tx_length, rx_length, frame_ident, parity_bits}, 0);
    chk(lin_mode, 1'b0);
    wr(8'h14, 32'h1);
    rd(8'h14, got);
    chk(got[0], 1'b0);
    i_lfb_engine_model.kick(1'b1);
    wr(8'h0C, 32'h5A);
    chk(uart_tx_data, 8'h5A);
    chk(tx_complete_flag, 1'b0);
    i_lfb_engine_model.q.push_back(8'h3C);
    got = 0;
    for (i = 0; i < 20 && got !== 32'h3C; i = i + 1)
      rd(8'h0C, got);
    chk(got, 32'h3C);
    close_out;
  end
endmodule
